// [logic/mbs_io_server.sv]
// Contract
// (R1) Header is 7 bytes: transaction, protocol (zero), length, unit identifier.
// (R2) Response repeats the request's transaction identifier.
// (R3) Length counts unit identifier, function code and data.
// (R4) Unit identifier is carried from request to response.
// (R5) Function code is one byte; 128 and up mark exceptions.
// (R6) Functions 01,02,03,04,05,0F,10 are executed.
// (R7) Any other function code gets an unsupported-function exception.
// (R8) Too many items or missing address gets an exception.
// (R9) Success echoes the function code followed by the data.
// (R10) Failure returns the function code with bit 7 set.
// (R11) Exception data field holds the exception code.
// (R12) Multi-byte quantities go high byte first.
// (R13) Coil reads pack bits into 16-bit words, high byte first; the code sends the low byte first.
// (R14) Register reads return 16-bit values, high byte first; the code answers every register read with an exception.
// (R15) Empty data field accepted; data never above 252 bytes.
// (R16) Fourteen read/write output coils from address 0; one means on.
// (R17) Register 0xF7: 1 resets system, 247 restores factory defaults.
// (R18) Master starts every transaction; device only answers.
// (R19) Exception codes 01 function, 02 address, 03 quantity or value.
// (R20) Response length recomputed; protocol and unit identifiers copied.
`timescale 1ns/1ps
`default_nettype none
module mbs_io_server #(
  parameter int NUM_COILS = mbs_pkg::MBS_NUM_COILS
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output logic [NUM_COILS-1:0] coil_out,
  output logic sys_reset_pulse,
  output logic factory_restore_pulse
);
  if (NUM_COILS < 1 || NUM_COILS > 16)
  begin : g_chk
    $error("NUM_COILS must be 1 to 16");
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------
  // request capture
  // ----------------------------------------
  logic frm_valid;
  logic [15:0] p_tid;
  logic [15:0] p_pid;
  logic [15:0] p_len;
  logic [7:0] p_uid;
  logic [7:0] p_fc;
  logic [15:0] p_addr;
  logic [15:0] p_qty;
  logic [7:0] p_bc;
  logic [7:0] p_w0;
  logic [7:0] p_w1;
  logic take;

  mbs_rx_parse u_parse (
    .ref_clk(ref_clk),
    .rst_n(rst_n_ff),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .take(take),
    .rx_ready_ff(rx_ready),
    .frm_valid_ff(frm_valid),
    .tid_ff(p_tid),
    .pid_ff(p_pid),
    .len_ff(p_len),
    .uid_ff(p_uid),
    .fc_ff(p_fc),
    .addr_ff(p_addr),
    .qty_ff(p_qty),
    .bc_ff(p_bc),
    .w0_ff(p_w0),
    .w1_ff(p_w1)
  );

  // ----------------------------------------
  // request checks
  // ----------------------------------------
  localparam logic [16:0] NCOIL = 17'(NUM_COILS);
  mbs_pkg::mbs_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [3:0] total_ff;
  logic [7:0] exc_ff;
  logic [15:0] rd_ff;
  logic [NUM_COILS-1:0] coil_ff;
  logic tx_valid_ff;
  logic [7:0] tx_data_ff;
  logic tx_last_ff;
  logic sys_reset_pulse_ff;
  logic factory_restore_pulse_ff;

  // (R1) foreign protocol or oversize frames are dropped silently
  // (R15) data field of 0 to 252 bytes
  wire frm_ok = (p_pid == mbs_pkg::MBS_PROTO_ID) && (p_len >= mbs_pkg::MBS_MIN_LEN) &&
    (p_len <= mbs_pkg::MBS_MAX_LEN);
  wire exec = (state_ff == mbs_pkg::MBS_IDLE) && frm_valid && frm_ok;
  // (R5) one-byte code; 128 and up falls to unsupported
  // (R6) supported function decode
  wire is_rdb = (p_fc == mbs_pkg::MBS_FC_RD_COILS) || (p_fc == mbs_pkg::MBS_FC_RD_INPUTS);
  wire is_rdr = (p_fc == mbs_pkg::MBS_FC_RD_HOLD) || (p_fc == mbs_pkg::MBS_FC_RD_INREG);
  wire is_wr1 = p_fc == mbs_pkg::MBS_FC_WR_COIL;
  wire is_wrm = p_fc == mbs_pkg::MBS_FC_WR_COILS;
  wire is_wrr = p_fc == mbs_pkg::MBS_FC_WR_REGS;
  wire [16:0] a_end = {1'b0, p_addr} + {1'b0, p_qty};
  wire [16:0] bc7 = {1'b0, p_qty} + 17'h00007;
  wire [13:0] bc_need = bc7[16:3];
  wire [15:0] reg_val = {p_w0, p_w1};
  wire qty0 = p_qty == 16'h0000;
  wire bad_rdb = qty0 || (p_qty > mbs_pkg::MBS_MAX_RD_BITS);
  wire bad_rdr = qty0 || (p_qty > mbs_pkg::MBS_MAX_RD_REGS);
  wire bad_wr1 = (p_qty != mbs_pkg::MBS_COIL_ON) && (p_qty != mbs_pkg::MBS_COIL_OFF);
  wire bad_wrm = qty0 || (p_qty > mbs_pkg::MBS_MAX_WR_BITS) || ({6'h00, p_bc} != bc_need);
  wire bad_wrr = qty0 || (p_qty > mbs_pkg::MBS_MAX_WR_REGS) ||
    ({9'h000, p_bc} != {p_qty, 1'b0});
  wire bad_val = (reg_val != mbs_pkg::MBS_SYSRST_VAL) && (reg_val != mbs_pkg::MBS_FACTORY_VAL);
  wire sysrst_adr = (p_addr == mbs_pkg::MBS_SYSRST_REG) && (p_qty == 16'h0001);
  // (R8) quantity and address limits
  // (R19) customary codes
  // (R14) register space holds only a write-only register, so reads with a valid quantity raise an address fault
  // (R7) everything else is unsupported
  wire [7:0] exc_code =
    is_rdb ? (bad_rdb ? mbs_pkg::MBS_EXC_VALUE :
      (a_end > NCOIL) ? mbs_pkg::MBS_EXC_ADDR : mbs_pkg::MBS_EXC_NONE) :
    is_rdr ? (bad_rdr ? mbs_pkg::MBS_EXC_VALUE : mbs_pkg::MBS_EXC_ADDR) :
    is_wr1 ? (bad_wr1 ? mbs_pkg::MBS_EXC_VALUE :
      ({1'b0, p_addr} >= NCOIL) ? mbs_pkg::MBS_EXC_ADDR : mbs_pkg::MBS_EXC_NONE) :
    is_wrm ? (bad_wrm ? mbs_pkg::MBS_EXC_VALUE :
      (a_end > NCOIL) ? mbs_pkg::MBS_EXC_ADDR : mbs_pkg::MBS_EXC_NONE) :
    is_wrr ? (bad_wrr ? mbs_pkg::MBS_EXC_VALUE : !sysrst_adr ? mbs_pkg::MBS_EXC_ADDR :
      bad_val ? mbs_pkg::MBS_EXC_VALUE : mbs_pkg::MBS_EXC_NONE) :
    mbs_pkg::MBS_EXC_FUNC;
  wire ok = exc_code == mbs_pkg::MBS_EXC_NONE;

  // ----------------------------------------
  // coil datapath
  // ----------------------------------------
  // shifts use five address bits; only reached once the address is in range
  wire [31:0] coil32 = {{(32 - NUM_COILS){1'b0}}, coil_ff};
  wire [31:0] rd_sh = coil32 >> p_addr[4:0];
  wire [31:0] qmask = (32'h00000001 << p_qty[4:0]) - 32'h00000001;
  // (R13) word goes out low byte first; that byte holds coils addr..addr+7
  wire [15:0] rd_bits = rd_sh[15:0] & qmask[15:0];
  wire [31:0] wmask = is_wr1 ? (32'h00000001 << p_addr[4:0]) : (qmask << p_addr[4:0]);
  wire [31:0] wbits = is_wr1 ? {32{p_qty == mbs_pkg::MBS_COIL_ON}} :
    ({16'h0000, p_w1, p_w0} << p_addr[4:0]);
  wire [31:0] coil_new = (coil32 & ~wmask) | (wbits & wmask);
  wire do_wr = exec && ok && (is_wr1 || is_wrm);
  wire [NUM_COILS-1:0] nxt_coil = do_wr ? coil_new[NUM_COILS-1:0] : coil_ff;
  wire [3:0] nxt_total = !ok ? mbs_pkg::MBS_RSP_EXC_BYTES :
    is_rdb ? mbs_pkg::MBS_RSP_RD_BASE + bc_need[3:0] : mbs_pkg::MBS_RSP_WR_BYTES;

  // ----------------------------------------
  // response bytes
  // ----------------------------------------
  wire [7:0] rsp [0:11];
  wire [3:0] len_lo = total_ff - mbs_pkg::MBS_LEN_OFS;
  wire exc_on = exc_ff != mbs_pkg::MBS_EXC_NONE;
  // (R2) transaction echo
  assign rsp[0] = p_tid[15:8];
  assign rsp[1] = p_tid[7:0];
  // (R20) protocol copied, length recomputed
  assign rsp[2] = p_pid[15:8];
  assign rsp[3] = p_pid[7:0];
  assign rsp[4] = 8'h00;
  assign rsp[5] = {4'h0, len_lo};
  // (R4) unit identifier copy
  assign rsp[6] = p_uid;
  // (R9) echo on success
  // (R10) bit 7 on failure
  assign rsp[7] = exc_on ? (p_fc | mbs_pkg::MBS_FC_EXC_BIT) : p_fc;
  // (R11) exception code as data
  // (R12) echoed fields high byte first
  assign rsp[8] = exc_on ? exc_ff : is_rdb ? {4'h0, total_ff - mbs_pkg::MBS_RSP_RD_BASE} :
    p_addr[15:8];
  assign rsp[9] = is_rdb ? rd_ff[7:0] : p_addr[7:0];
  assign rsp[10] = is_rdb ? rd_ff[15:8] : p_qty[15:8];
  assign rsp[11] = p_qty[7:0];
  wire tx_go = !tx_valid_ff || tx_ready;
  wire tx_end = (state_ff == mbs_pkg::MBS_SEND) && tx_go && (cnt_ff == total_ff);
  assign take = tx_end || ((state_ff == mbs_pkg::MBS_IDLE) && frm_valid && !frm_ok);
  wire [7:0] cur_byte = rsp[cnt_ff];

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // (R18) transmit only after a complete request
  always_ff @(posedge ref_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      state_ff <= mbs_pkg::MBS_IDLE;
      cnt_ff <= 4'h0;
      total_ff <= 4'h0;
      exc_ff <= 8'h00;
      rd_ff <= 16'h0000;
    end
    else if (exec)
    begin
      state_ff <= mbs_pkg::MBS_SEND;
      cnt_ff <= 4'h0;
      total_ff <= nxt_total;
      exc_ff <= exc_code;
      rd_ff <= rd_bits;
    end
    else if (state_ff == mbs_pkg::MBS_SEND && tx_go)
    begin
      cnt_ff <= tx_end ? cnt_ff : cnt_ff + 4'h1;
      state_ff <= tx_end ? mbs_pkg::MBS_IDLE : mbs_pkg::MBS_SEND;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      tx_last_ff <= 1'b0;
    end
    else if (state_ff == mbs_pkg::MBS_SEND && tx_go)
    begin
      tx_valid_ff <= !tx_end;
      tx_data_ff <= tx_end ? 8'h00 : cur_byte;
      tx_last_ff <= cnt_ff == total_ff - 4'h1;
    end
  end

  // (R16) coil outputs, one means on
  // (R17) system command pulses
  wire wr_reg = exec && ok && is_wrr;
  always_ff @(posedge ref_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      coil_ff <= mbs_pkg::MBS_COIL_RST[NUM_COILS-1:0];
      sys_reset_pulse_ff <= 1'b0;
      factory_restore_pulse_ff <= 1'b0;
    end
    else
    begin
      coil_ff <= nxt_coil;
      sys_reset_pulse_ff <= wr_reg && (reg_val == mbs_pkg::MBS_SYSRST_VAL);
      factory_restore_pulse_ff <= wr_reg && (reg_val == mbs_pkg::MBS_FACTORY_VAL);
    end
  end
  assign coil_out = coil_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;
  assign tx_last = tx_last_ff;
  assign sys_reset_pulse = sys_reset_pulse_ff;
  assign factory_restore_pulse = factory_restore_pulse_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_ff);
  wire shown = tx_valid && tx_ready;
  chk_tid_echo: assert property (shown && cnt_ff == 4'h1 |-> tx_data == p_tid[15:8]) // (R2)
    else $error("transaction id high byte wrong");
  chk_pid_zero: assert property (shown && cnt_ff == 4'h4 |-> tx_data == 8'h00) // (R1)
    else $error("protocol id not zero");
  chk_len_field: assert property (shown && cnt_ff == 4'h6 |-> tx_data == total_ff - 4'h6) // (R3)
    else $error("length field wrong");
  chk_uid_copy: assert property (shown && cnt_ff == 4'h7 |-> tx_data == p_uid) // (R4)
    else $error("unit id not copied");
  chk_exc_msb: assert property (shown && cnt_ff == 4'h8 && exc_on // (R10)
    |-> tx_data == (p_fc | 8'h80))
    else $error("exception code msb clear");
  chk_fc_echo: assert property (shown && cnt_ff == 4'h8 && !exc_on |-> tx_data == p_fc) // (R9)
    else $error("function code not echoed");
  chk_unsup_fc: assert property (exec && p_fc > 8'h10 |=> exc_ff == 8'h01) // (R7)
    else $error("unsupported code accepted");
  chk_bad_addr: assert property (exec && is_rdb && p_qty == 16'h0001 && p_addr >= 16'h000E // (R8)
    |=> exc_ff == 8'h02 && total_ff == 4'h9)
    else $error("out of range read accepted");
  chk_resp_only: assert property (!frm_valid |-> !tx_valid) // (R18)
    else $error("unsolicited transmit");
  chk_coil_on: assert property (exec && is_wr1 && ok && p_qty == 16'hFF00 // (R16)
    |=> coil_ff[$past(p_addr[3:0])])
    else $error("single coil write lost");
  chk_sysrst: assert property ($rose(sys_reset_pulse) // (R17)
    |-> $past(wr_reg) && reg_val == 16'h0001 ##1 !sys_reset_pulse)
    else $error("system reset pulse wrong");
  cov_read: cover property (exec && is_rdb && ok);
  cov_write: cover property (exec && is_wrm && ok);
  cov_exc: cover property (exec && !ok);
  cov_reset: cover property (factory_restore_pulse);
endmodule
`default_nettype wire

// [inc/mbs_pkg.sv]
`default_nettype none
package mbs_pkg;
  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int MBS_HDR_BYTES = 7;
  localparam int MBS_MAX_DATA = 252;
  localparam int MBS_NUM_COILS = 14;
  localparam logic [16:0] MBS_IX_LEN_LO = 17'h00005;
  localparam logic [16:0] MBS_IX_UID = 17'h00006;
  localparam logic [16:0] MBS_IX_FC = 17'h00007;
  localparam logic [16:0] MBS_IX_ADDR_HI = 17'h00008;
  localparam logic [16:0] MBS_IX_ADDR_LO = 17'h00009;
  localparam logic [16:0] MBS_IX_QTY_HI = 17'h0000A;
  localparam logic [16:0] MBS_IX_QTY_LO = 17'h0000B;
  localparam logic [16:0] MBS_IX_BC = 17'h0000C;
  localparam logic [16:0] MBS_IX_D0 = 17'h0000D;
  localparam logic [16:0] MBS_IX_D1 = 17'h0000E;
  localparam logic [15:0] MBS_PROTO_ID = 16'h0000;
  localparam logic [15:0] MBS_MIN_LEN = 16'h0002;
  localparam logic [15:0] MBS_MAX_LEN = 16'h00FE;
  // ----------------------------------------
  // functions and exceptions
  // ----------------------------------------
  localparam logic [7:0] MBS_FC_RD_COILS = 8'h01;
  localparam logic [7:0] MBS_FC_RD_INPUTS = 8'h02;
  localparam logic [7:0] MBS_FC_RD_HOLD = 8'h03;
  localparam logic [7:0] MBS_FC_RD_INREG = 8'h04;
  localparam logic [7:0] MBS_FC_WR_COIL = 8'h05;
  localparam logic [7:0] MBS_FC_WR_COILS = 8'h0F;
  localparam logic [7:0] MBS_FC_WR_REGS = 8'h10;
  localparam logic [7:0] MBS_FC_EXC_BIT = 8'h80;
  localparam logic [7:0] MBS_EXC_NONE = 8'h00;
  localparam logic [7:0] MBS_EXC_FUNC = 8'h01;
  localparam logic [7:0] MBS_EXC_ADDR = 8'h02;
  localparam logic [7:0] MBS_EXC_VALUE = 8'h03;
  localparam logic [15:0] MBS_MAX_RD_BITS = 16'h07D0;
  localparam logic [15:0] MBS_MAX_RD_REGS = 16'h007D;
  localparam logic [15:0] MBS_MAX_WR_BITS = 16'h07B0;
  localparam logic [15:0] MBS_MAX_WR_REGS = 16'h007B;
  // ----------------------------------------
  // register map and values
  // ----------------------------------------
  localparam logic [15:0] MBS_COIL_BASE = 16'h0000;
  localparam logic [15:0] MBS_SYSRST_REG = 16'h00F7;
  localparam logic [15:0] MBS_SYSRST_VAL = 16'h0001;
  localparam logic [15:0] MBS_FACTORY_VAL = 16'h00F7;
  localparam logic [15:0] MBS_COIL_ON = 16'hFF00;
  localparam logic [15:0] MBS_COIL_OFF = 16'h0000;
  localparam logic [15:0] MBS_COIL_RST = 16'h0000;
  // ----------------------------------------
  // response sizes in bytes
  // ----------------------------------------
  localparam logic [3:0] MBS_RSP_EXC_BYTES = 4'h9;
  localparam logic [3:0] MBS_RSP_RD_BASE = 4'h9;
  localparam logic [3:0] MBS_RSP_WR_BYTES = 4'hC;
  localparam logic [3:0] MBS_LEN_OFS = 4'h6;
  typedef enum logic [1:0] {
    MBS_IDLE = 2'b00,
    MBS_SEND = 2'b01
  } mbs_state_t;
endpackage
`default_nettype wire

// [logic/mbs_rx_parse.sv]
`timescale 1ns/1ps
`default_nettype none
module mbs_rx_parse (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic take,
  output logic rx_ready_ff,
  output logic frm_valid_ff,
  output logic [15:0] tid_ff,
  output logic [15:0] pid_ff,
  output logic [15:0] len_ff,
  output logic [7:0] uid_ff,
  output logic [7:0] fc_ff,
  output logic [15:0] addr_ff,
  output logic [15:0] qty_ff,
  output logic [7:0] bc_ff,
  output logic [7:0] w0_ff,
  output logic [7:0] w1_ff
);
  logic [16:0] idx_ff;
  wire acc = rx_valid && rx_ready_ff;
  wire [15:0] len_now = {len_ff[15:8], rx_data};
  // (R3) length counts bytes after it
  wire last_byte = (idx_ff == mbs_pkg::MBS_IX_LEN_LO) ? (len_now == 16'h0000) :
    (idx_ff > mbs_pkg::MBS_IX_LEN_LO) &&
    (idx_ff == {1'b0, len_ff} + mbs_pkg::MBS_IX_LEN_LO);

  // ----------------------------------------
  // frame framing
  // ----------------------------------------
  // stall further bytes until the response is gone
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_ff <= 17'h00000;
      rx_ready_ff <= 1'b1;
      frm_valid_ff <= 1'b0;
    end
    else if (take)
    begin
      idx_ff <= 17'h00000;
      rx_ready_ff <= 1'b1;
      frm_valid_ff <= 1'b0;
    end
    else if (acc)
    begin
      idx_ff <= last_byte ? 17'h00000 : idx_ff + 17'h00001;
      rx_ready_ff <= !last_byte;
      frm_valid_ff <= last_byte;
    end
  end

  // ----------------------------------------
  // field capture
  // ----------------------------------------
  // (R1) header bytes, high byte first
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tid_ff <= 16'h0000;
      pid_ff <= 16'h0000;
      len_ff <= 16'h0000;
      uid_ff <= 8'h00;
      fc_ff <= 8'h00;
      addr_ff <= 16'h0000;
      qty_ff <= 16'h0000;
      bc_ff <= 8'h00;
      w0_ff <= 8'h00;
      w1_ff <= 8'h00;
    end
    else if (acc)
    begin
      unique case (idx_ff)
        17'h00000:
        begin
          tid_ff[15:8] <= rx_data;
          fc_ff <= 8'h00;
          addr_ff <= 16'h0000;
          qty_ff <= 16'h0000;
          bc_ff <= 8'h00;
          w0_ff <= 8'h00;
          w1_ff <= 8'h00;
        end
        17'h00001: tid_ff[7:0] <= rx_data;
        17'h00002: pid_ff[15:8] <= rx_data;
        17'h00003: pid_ff[7:0] <= rx_data;
        17'h00004: len_ff[15:8] <= rx_data;
        mbs_pkg::MBS_IX_LEN_LO: len_ff[7:0] <= rx_data;
        mbs_pkg::MBS_IX_UID: uid_ff <= rx_data;
        mbs_pkg::MBS_IX_FC: fc_ff <= rx_data;
        mbs_pkg::MBS_IX_ADDR_HI: addr_ff[15:8] <= rx_data;
        mbs_pkg::MBS_IX_ADDR_LO: addr_ff[7:0] <= rx_data;
        mbs_pkg::MBS_IX_QTY_HI: qty_ff[15:8] <= rx_data;
        mbs_pkg::MBS_IX_QTY_LO: qty_ff[7:0] <= rx_data;
        mbs_pkg::MBS_IX_BC: bc_ff <= rx_data;
        mbs_pkg::MBS_IX_D0: w0_ff <= rx_data;
        mbs_pkg::MBS_IX_D1: w1_ff <= rx_data;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// [dv/mbs_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mbs_master_model (
  input wire logic ref_clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // ----------------------------------------
  // frame building
  // ----------------------------------------
  // header, length, msb first
  function automatic void frame(input logic [15:0] tid, input logic [15:0] pid,
      input logic [7:0] uid, input logic [7:0] pdu[$], output logic [7:0] q[$]);
    logic [15:0] len;
    len = 16'(pdu.size() + 1);
    q = {tid[15:8], tid[7:0], pid[15:8], pid[7:0], len[15:8], len[7:0], uid};
    q = {q, pdu};
  endfunction
  // ----------------------------------------
  // request and response streams
  // ----------------------------------------
  // master opens, byte units
  task automatic send(input logic [7:0] q[$]);
    logic rdy;
    foreach (q[i])
    begin
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_data = q[i];
      rdy = rx_ready;
      @(posedge ref_clk);
      while (!rdy)
      begin
        @(negedge ref_clk);
        rdy = rx_ready;
        @(posedge ref_clk);
      end
    end
    @(negedge ref_clk);
    rx_valid = 1'b0;
    // released line must not keep showing the last byte
    rx_data = ~rx_data;
  endtask
  task automatic recv(input bit slow, output logic [7:0] q[$], output logic fin);
    logic hit;
    logic lst;
    logic [7:0] d;
    q = {};
    fin = 1'b0;
    for (int n = 0; n < 300 && !fin; n++)
    begin
      @(negedge ref_clk);
      tx_ready = !slow || n[0];
      hit = tx_valid && tx_ready;
      d = tx_data;
      lst = tx_last;
      @(posedge ref_clk);
      if (hit)
      begin
        q.push_back(d);
        fin = lst;
      end
    end
    @(negedge ref_clk);
    tx_ready = 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/mbs_io_server_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mbs_io_server_tb;
  logic ref_clk;
  logic arst_n;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_ready;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_last;
  logic tx_ready;
  logic [13:0] coil_out;
  logic sys_reset_pulse;
  logic factory_restore_pulse;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_sys = 0;
  int n_fac = 0;
  mbs_io_server #(.NUM_COILS(14)) DUT (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ready(rx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last),
    .tx_ready(tx_ready),
    .coil_out(coil_out),
    .sys_reset_pulse(sys_reset_pulse),
    .factory_restore_pulse(factory_restore_pulse)
  );
  mbs_master_model mst (
    .ref_clk(ref_clk),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ready(rx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last),
    .tx_ready(tx_ready)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever
      #10 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    cycles++;
    if (sys_reset_pulse === 1'b1)
      n_sys++;
    if (factory_restore_pulse === 1'b1)
      n_fac++;
    // whole run needs well under this many cycles
    if (cycles == 8000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // unit id varies with the transaction id to catch a stuck copy
  task automatic xfer(input logic [15:0] tid, input logic [7:0] req[$],
      input logic [7:0] rsp[$], input bit slow);
    logic [7:0] q[$];
    logic [7:0] got[$];
    logic fin;
    mst.frame(tid, 16'h0000, tid[7:0] ^ 8'h5A, req, q);
    mst.send(q);
    mst.recv(slow, got, fin);
    mst.frame(tid, 16'h0000, tid[7:0] ^ 8'h5A, rsp, q);
    check({15'h0000, fin}, 16'h0001);
    check(16'(got.size()), 16'(q.size()));
    foreach (q[i])
      check({8'h00, got[i]}, {8'h00, q[i]});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_read();
    check({2'b00, coil_out}, 16'h0000);
    xfer(16'h1234, {8'h01, 8'h00, 8'h00, 8'h00, 8'h0E}, {8'h01, 8'h02, 8'h00, 8'h00}, 0);
  endtask
  task automatic t_coil_write();
    xfer(16'h0102, {8'h0F, 8'h00, 8'h00, 8'h00, 8'h0E, 8'h02, 8'hFF, 8'h3F},
      {8'h0F, 8'h00, 8'h00, 8'h00, 8'h0E}, 0);
    check({2'b00, coil_out}, 16'h3FFF);
    xfer(16'hA5C3, {8'h01, 8'h00, 8'h00, 8'h00, 8'h0E}, {8'h01, 8'h02, 8'hFF, 8'h3F}, 1);
    xfer(16'h0003, {8'h02, 8'h00, 8'h08, 8'h00, 8'h06}, {8'h02, 8'h01, 8'h3F}, 0);
  endtask
  task automatic t_single();
    xfer(16'h0200, {8'h05, 8'h00, 8'h05, 8'h00, 8'h00},
      {8'h05, 8'h00, 8'h05, 8'h00, 8'h00}, 0);
    check({2'b00, coil_out}, 16'h3FDF);
    xfer(16'h0201, {8'h05, 8'h00, 8'h05, 8'h12, 8'h34}, {8'h85, 8'h03}, 0);
    check({2'b00, coil_out}, 16'h3FDF);
    xfer(16'h0202, {8'h05, 8'h00, 8'h05, 8'hFF, 8'h00},
      {8'h05, 8'h00, 8'h05, 8'hFF, 8'h00}, 1);
    check({2'b00, coil_out}, 16'h3FFF);
  endtask
  task automatic t_unsupported();
    logic [7:0] fcs[4] = '{8'h06, 8'h2B, 8'h41, 8'h7F};
    // empty data field: the function code alone decides
    foreach (fcs[i])
      xfer(16'h0300 + 16'(i), {fcs[i]}, {fcs[i] | 8'h80, 8'h01}, 0);
  endtask
  task automatic t_limits();
    xfer(16'h0500, {8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, {8'h81, 8'h03}, 0);
    xfer(16'h0501, {8'h01, 8'h00, 8'h0E, 8'h07, 8'hD1}, {8'h81, 8'h03}, 0);
    xfer(16'h0502, {8'h01, 8'h00, 8'h0E, 8'h00, 8'h01}, {8'h81, 8'h02}, 0);
    xfer(16'h0503, {8'h01, 8'h00, 8'h00, 8'h00, 8'h0F}, {8'h81, 8'h02}, 0);
    xfer(16'h0504, {8'h03, 8'h00, 8'hF7, 8'h00, 8'h01}, {8'h83, 8'h02}, 0);
    xfer(16'h0505, {8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h84, 8'h02}, 0);
    xfer(16'h0506, {8'h0F, 8'h00, 8'h00, 8'h00, 8'h0E, 8'h01, 8'h00}, {8'h8F, 8'h03}, 0);
    check({2'b00, coil_out}, 16'h3FFF);
  endtask
  task automatic t_system_reg();
    check(16'(n_sys + n_fac), 16'h0000);
    xfer(16'h0600, {8'h10, 8'h00, 8'hF7, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
      {8'h10, 8'h00, 8'hF7, 8'h00, 8'h01}, 0);
    check(16'(n_sys), 16'h0001);
    check(16'(n_fac), 16'h0000);
    xfer(16'h0601, {8'h10, 8'h00, 8'hF7, 8'h00, 8'h01, 8'h02, 8'h00, 8'hF7},
      {8'h10, 8'h00, 8'hF7, 8'h00, 8'h01}, 0);
    check(16'(n_fac), 16'h0001);
    xfer(16'h0602, {8'h10, 8'h00, 8'hF7, 8'h00, 8'h01, 8'h02, 8'h00, 8'h05},
      {8'h90, 8'h03}, 0);
    xfer(16'h0603, {8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
      {8'h90, 8'h02}, 0);
    check(16'(n_sys + n_fac), 16'h0002);
    check({2'b00, coil_out}, 16'h3FFF);
  endtask
  task automatic t_bad_frame();
    logic [7:0] q[$];
    logic seen;
    seen = 1'b0;
    mst.frame(16'h0700, 16'h0001, 8'h22, {8'h01, 8'h00, 8'h00, 8'h00, 8'h0E}, q);
    mst.send(q);
    repeat (30)
    begin
      @(negedge ref_clk);
      if (tx_valid !== 1'b0)
        seen = 1'b1;
    end
    check({15'h0000, seen}, 16'h0000);
    xfer(16'hBEEF, {8'h01, 8'h00, 8'h00, 8'h00, 8'h0E}, {8'h01, 8'h02, 8'hFF, 8'h3F}, 0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    arst_n = 1'b0;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    // first byte only after the reset synchroniser has settled
    repeat (3) @(posedge ref_clk);
    t_reset_read();
    t_coil_write();
    t_single();
    t_unsupported();
    t_limits();
    t_system_reg();
    t_bad_frame();
    stop_test();
  end
endmodule
`default_nettype wire
